// ===== shared/ccr_pkg.sv
package ccr_pkg;

    // Register word and address widths of the serial register interface
    localparam int unsigned ADDR_W = 6;
    localparam int unsigned DATA_W = 16;
    localparam int unsigned CAL_W  = 24;

    // Register addresses
    localparam logic [5:0] CH4_GAIN_TRIM_HIGH_ADDR   = 6'h20;
    localparam logic [5:0] CH4_GAIN_TRIM_LOW_ADDR    = 6'h21;
    localparam logic [5:0] CH5_CHANNEL_SETUP_ADDR    = 6'h22;
    localparam logic [5:0] CH5_OFFSET_TRIM_HIGH_ADDR = 6'h23;
    localparam logic [5:0] CH5_OFFSET_TRIM_LOW_ADDR  = 6'h24;

    // Reset values
    localparam logic [15:0] CH4_GAIN_TRIM_HIGH_RST   = 16'h8000;
    localparam logic [15:0] CH4_GAIN_TRIM_LOW_RST    = 16'h0000;
    localparam logic [15:0] CH5_CHANNEL_SETUP_RST    = 16'h0000;
    localparam logic [15:0] CH5_OFFSET_TRIM_HIGH_RST = 16'h0000;
    localparam logic [15:0] CH5_OFFSET_TRIM_LOW_RST  = 16'h0000;

    // Writable bits of each word; everything else reads zero
    localparam logic [15:0] TRIM_LOW_WMASK = 16'hFF00;
    localparam logic [15:0] SETUP_WMASK    = 16'hFFC7;

    // Field positions inside the setup word and the trim low words
    localparam int unsigned DELAY_LSB     = 6;
    localparam int unsigned DELAY_W       = 10;
    localparam int unsigned HP_OFF_BIT    = 2;
    localparam int unsigned SEL_LSB       = 0;
    localparam int unsigned SEL_W         = 2;
    localparam int unsigned LOW_BYTE_LSB  = 8;
    localparam int unsigned LOW_BYTE_W    = 8;

    // Channel 5 input sources
    typedef enum logic [1:0] {
        CCR_SRC_PINS    = 2'h0,
        CCR_SRC_SHORTED = 2'h1,
        CCR_SRC_TEST_P  = 2'h2,
        CCR_SRC_TEST_N  = 2'h3
    } ccr_src_t;

    // Joins a 24-bit value from its high word and the top byte of its low word
    function automatic logic [23:0] ccr_join(input logic [15:0] hi, input logic [15:0] lo);
        ccr_join = {hi, lo[15:8]};
    endfunction : ccr_join

endpackage : ccr_pkg

// ===== src/ccr_input_mux.sv
`timescale 1ns/1ps
// Picks the sample fed to the channel 5 datapath from the setup field
module ccr_input_mux #(
    parameter int unsigned SAMPLE_W = 24
) (
    // Clock and reset
    input  wire logic                       clk_i,
    input  wire logic                       rst_i,
    // Selection
    input  wire ccr_pkg::ccr_src_t          sel_i,
    // Candidate sources
    input  wire logic signed [SAMPLE_W-1:0] pin_sample_i,
    input  wire logic signed [SAMPLE_W-1:0] test_level_i,
    // Selected sample
    output logic signed [SAMPLE_W-1:0]      sample_o
);
    import ccr_pkg::*;

    logic signed [SAMPLE_W-1:0] pick;

    // Shorted inputs give a zero differential sample
    assign pick = (sel_i == CCR_SRC_PINS)    ? pin_sample_i :
                  (sel_i == CCR_SRC_SHORTED) ? '0 :
                  (sel_i == CCR_SRC_TEST_P)  ? test_level_i :
                                               -test_level_i;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            sample_o <= '0;
        end else begin
            sample_o <= pick;
        end
    end

endmodule : ccr_input_mux

// ===== src/ccr_trim_apply.sv
`timescale 1ns/1ps
// Applies offset then gain to one conversion result, one stage of registers
module ccr_trim_apply #(
    parameter int unsigned SAMPLE_W = 24
) (
    // Clock and reset
    input  wire logic                       clk_i,
    input  wire logic                       rst_i,
    // Trim operands
    input  wire logic [23:0]                gain_i,
    input  wire logic signed [23:0]         offset_i,
    // Conversion stream
    input  wire logic                       valid_i,
    input  wire logic signed [SAMPLE_W-1:0] sample_i,
    output logic                            valid_o,
    output logic signed [SAMPLE_W-1:0]      sample_o
);
    import ccr_pkg::*;

    localparam int unsigned SUM_W  = SAMPLE_W + 1;
    localparam int unsigned PROD_W = SUM_W + 25;
    localparam logic signed [SUM_W-1:0] MAX_V = SUM_W'((1 << (SAMPLE_W - 1)) - 1);
    localparam logic signed [SUM_W-1:0] MIN_V = -MAX_V - SUM_W'(1);

    logic signed [SUM_W-1:0]  sum;
    logic signed [PROD_W-1:0] prod;
    logic signed [PROD_W-1:0] scaled;
    logic signed [SUM_W-1:0]  clip;

    assign sum    = SUM_W'(sample_i) + SUM_W'(offset_i);
    // Gain is unsigned with unity at bit 23, so scale by 2^-23
    assign prod   = PROD_W'(sum) * PROD_W'($signed({1'b0, gain_i}));
    assign scaled = prod >>> 23;
    // Saturate rather than wrap so a large trim never flips the sign
    assign clip   = (scaled > PROD_W'(MAX_V)) ? MAX_V :
                    (scaled < PROD_W'(MIN_V)) ? MIN_V : SUM_W'(scaled);

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            valid_o  <= 1'b0;
            sample_o <= '0;
        end else begin
            valid_o  <= valid_i;
            sample_o <= clip[SAMPLE_W-1:0];
        end
    end

endmodule : ccr_trim_apply

// ===== src/ccr_channel_calibration_config_regs.sv
`timescale 1ns/1ps
// What this block does
// - The channel 4 gain high word holds gain bits 23 to 8 in its bits 15 to 0.
// - The 24-bit gain is an unsigned fraction from zero up to just under two.
// - Gain bits 7 to 0 sit in bits 15 to 8 of the channel 4 gain low word.
// - The low byte of every trim low word reads zero and ignores writes.
// - The gain high word at 20h resets to 8000h and every other word to zero.
// - Setup bits 15 to 6 are a signed delay in modulator clock cycles for channel 5.
// - Setup bit 2 clear leaves the global high-pass setting in charge, set forces it off.
// - Setup bits 1 to 0 pick own pins, shorted, positive test or negative test input.
// - The channel 5 offset high word holds offset bits 23 to 8 in its bits 15 to 0.
// - Offset bits 7 to 0 sit in bits 15 to 8 of the channel 5 offset low word.
module ccr_channel_calibration_config_regs #(
    parameter int unsigned SAMPLE_W = 24
) (
    // Clock and reset
    input  wire logic                       clk_i,
    input  wire logic                       rst_i,
    // Register access from the serial interface
    input  wire logic                       reg_wr_i,
    input  wire logic                       reg_rd_i,
    input  wire logic [ccr_pkg::ADDR_W-1:0] reg_addr_i,
    input  wire logic [ccr_pkg::DATA_W-1:0] reg_wdata_i,
    output logic [ccr_pkg::DATA_W-1:0]      reg_rdata_o,
    output logic                            reg_hit_o,
    // Global high-pass setting for channel 5
    input  wire logic                       global_highpass_setting_i,
    // Channel 5 controls
    output logic signed [9:0]               ch5_sample_delay_o,
    output logic                            ch5_highpass_en_o,
    output ccr_pkg::ccr_src_t               ch5_input_select_o,
    // Assembled trims
    output logic [23:0]                     ch4_gain_o,
    output logic signed [23:0]              ch5_offset_o,
    // Channel 4 conversion stream
    input  wire logic                       ch4_valid_i,
    input  wire logic signed [SAMPLE_W-1:0] ch4_sample_i,
    output logic                            ch4_valid_o,
    output logic signed [SAMPLE_W-1:0]      ch4_sample_o,
    // Channel 5 conversion stream
    input  wire logic                       ch5_valid_i,
    input  wire logic signed [SAMPLE_W-1:0] ch5_pin_sample_i,
    input  wire logic signed [SAMPLE_W-1:0] ch5_test_level_i,
    output logic                            ch5_valid_o,
    output logic signed [SAMPLE_W-1:0]      ch5_sample_o
);
    import ccr_pkg::*;

    logic [15:0] gain_hi_reg;
    logic [15:0] gain_lo_reg;
    logic [15:0] setup_reg;
    logic [15:0] offs_hi_reg;
    logic [15:0] offs_lo_reg;

    logic        sel_gain_hi;
    logic        sel_gain_lo;
    logic        sel_setup;
    logic        sel_offs_hi;
    logic        sel_offs_lo;
    logic        any_sel;
    logic [15:0] rd_mux;

    // Address decode
    assign sel_gain_hi = (reg_addr_i == CH4_GAIN_TRIM_HIGH_ADDR);
    assign sel_gain_lo = (reg_addr_i == CH4_GAIN_TRIM_LOW_ADDR);
    assign sel_setup   = (reg_addr_i == CH5_CHANNEL_SETUP_ADDR);
    assign sel_offs_hi = (reg_addr_i == CH5_OFFSET_TRIM_HIGH_ADDR);
    assign sel_offs_lo = (reg_addr_i == CH5_OFFSET_TRIM_LOW_ADDR);
    assign any_sel     = sel_gain_hi | sel_gain_lo | sel_setup | sel_offs_hi | sel_offs_lo;

    // Reserved bits are never stored, so they always read back as zero
    assign rd_mux = sel_gain_hi ? gain_hi_reg :
                    sel_gain_lo ? gain_lo_reg :
                    sel_setup   ? setup_reg   :
                    sel_offs_hi ? offs_hi_reg :
                    sel_offs_lo ? offs_lo_reg : 16'h0000;

    // Register storage
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            gain_hi_reg <= CH4_GAIN_TRIM_HIGH_RST;
            gain_lo_reg <= CH4_GAIN_TRIM_LOW_RST;
            setup_reg   <= CH5_CHANNEL_SETUP_RST;
            offs_hi_reg <= CH5_OFFSET_TRIM_HIGH_RST;
            offs_lo_reg <= CH5_OFFSET_TRIM_LOW_RST;
        end else if (reg_wr_i) begin
            if (sel_gain_hi) begin
                gain_hi_reg <= reg_wdata_i;
            end
            if (sel_gain_lo) begin
                gain_lo_reg <= reg_wdata_i & TRIM_LOW_WMASK;
            end
            if (sel_setup) begin
                setup_reg <= reg_wdata_i & SETUP_WMASK;
            end
            if (sel_offs_hi) begin
                offs_hi_reg <= reg_wdata_i;
            end
            if (sel_offs_lo) begin
                offs_lo_reg <= reg_wdata_i & TRIM_LOW_WMASK;
            end
        end
    end

    // Read port; answers one cycle after the read strobe
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            reg_rdata_o <= 16'h0000;
            reg_hit_o   <= 1'b0;
        end else if (reg_rd_i) begin
            reg_rdata_o <= rd_mux;
            reg_hit_o   <= any_sel;
        end
    end

    logic [23:0]        gain_next;
    logic signed [23:0] offs_next;
    logic               hp_en_next;

    // Gain stays unsigned: 800000h is unity, FFFFFFh just under two
    assign gain_next  = ccr_join(gain_hi_reg, gain_lo_reg);
    assign offs_next  = $signed(ccr_join(offs_hi_reg, offs_lo_reg));
    assign hp_en_next = setup_reg[HP_OFF_BIT] ? 1'b0 : global_highpass_setting_i;

    // Decoded controls, registered so every output leaves a flip-flop
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ch5_sample_delay_o <= '0;
            ch5_highpass_en_o  <= 1'b0;
            ch5_input_select_o <= CCR_SRC_PINS;
            ch4_gain_o         <= '0;
            ch5_offset_o       <= '0;
        end else begin
            ch5_sample_delay_o <= $signed(setup_reg[DELAY_LSB +: DELAY_W]);
            ch5_highpass_en_o  <= hp_en_next;
            ch5_input_select_o <= ccr_src_t'(setup_reg[SEL_LSB +: SEL_W]);
            ch4_gain_o         <= gain_next;
            ch5_offset_o       <= offs_next;
        end
    end

    // Channel 5 source selection; the sample is aligned with a delayed valid
    logic                       ch5_valid_d;
    logic signed [SAMPLE_W-1:0] ch5_selected;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ch5_valid_d <= 1'b0;
        end else begin
            ch5_valid_d <= ch5_valid_i;
        end
    end

    ccr_input_mux #(
        .SAMPLE_W (SAMPLE_W)
    ) u_ch5_mux (
        .clk_i        (clk_i),
        .rst_i        (rst_i),
        .sel_i        (ch5_input_select_o),
        .pin_sample_i (ch5_pin_sample_i),
        .test_level_i (ch5_test_level_i),
        .sample_o     (ch5_selected)
    );

    // Channel 4 gets offset-free gain trim, channel 5 offset at unity gain
    ccr_trim_apply #(
        .SAMPLE_W (SAMPLE_W)
    ) u_ch4_trim (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .gain_i   (ch4_gain_o),
        .offset_i (24'sh000000),
        .valid_i  (ch4_valid_i),
        .sample_i (ch4_sample_i),
        .valid_o  (ch4_valid_o),
        .sample_o (ch4_sample_o)
    );

    ccr_trim_apply #(
        .SAMPLE_W (SAMPLE_W)
    ) u_ch5_trim (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .gain_i   (24'h800000),
        .offset_i (ch5_offset_o),
        .valid_i  (ch5_valid_d),
        .sample_i (ch5_selected),
        .valid_o  (ch5_valid_o),
        .sample_o (ch5_sample_o)
    );

endmodule : ccr_channel_calibration_config_regs

// ===== bench/ccr_properties.sv
`timescale 1ns/1ps
module ccr_properties (
    input wire logic              clk_i,
    input wire logic              rst_i,
    input wire logic              reg_wr_i,
    input wire logic              reg_rd_i,
    input wire logic [5:0]        reg_addr_i,
    input wire logic [15:0]       reg_wdata_i,
    input wire logic [15:0]       reg_rdata_o,
    input wire logic              global_highpass_setting_i,
    input wire logic signed [9:0] ch5_sample_delay_o,
    input wire logic              ch5_highpass_en_o,
    input wire ccr_pkg::ccr_src_t ch5_input_select_o,
    input wire logic [23:0]       ch4_gain_o,
    input wire logic signed [23:0] ch5_offset_o
);
    import ccr_pkg::*;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic wa0, wa1, wa2, wa3, wa4;
    assign wa0 = reg_wr_i && reg_addr_i == 6'h20;
    assign wa1 = reg_wr_i && reg_addr_i == 6'h21;
    assign wa2 = reg_wr_i && reg_addr_i == 6'h22;
    assign wa3 = reg_wr_i && reg_addr_i == 6'h23;
    assign wa4 = reg_wr_i && reg_addr_i == 6'h24;
    AST_GAIN_RESET: assert property ($fell(rst_i) |=> ch4_gain_o == 24'h800000)
        else $error("gain trim not at unity after reset");
    AST_GAIN_HIGH: assert property (
        wa0 |-> ##2 ch4_gain_o[23:8] == $past(reg_wdata_i, 2))
        else $error("gain high word not in gain bits 23 to 8");
    AST_GAIN_LOW: assert property (
        wa1 |-> ##2 ch4_gain_o[7:0] == $past(reg_wdata_i[15:8], 2))
        else $error("gain low byte misplaced");
    AST_OFFS_HIGH: assert property (
        wa3 |-> ##2 ch5_offset_o[23:8] == $past(reg_wdata_i, 2))
        else $error("offset high word misplaced");
    AST_OFFS_LOW: assert property (
        wa4 |-> ##2 ch5_offset_o[7:0] == $past(reg_wdata_i[15:8], 2))
        else $error("offset low byte misplaced");
    AST_SETUP_FIELDS: assert property (
        wa2 |-> ##2 {ch5_sample_delay_o, ch5_input_select_o} ==
                    {$past(reg_wdata_i[15:6], 2), $past(reg_wdata_i[1:0], 2)})
        else $error("delay or input select field wrong");
    AST_HP_FORCED_OFF: assert property (
        wa2 && reg_wdata_i[2] |-> ##2 !ch5_highpass_en_o)
        else $error("high-pass not forced off");
    AST_HP_GLOBAL: assert property (
        !global_highpass_setting_i |=> !ch5_highpass_en_o)
        else $error("high-pass on while global setting off");
    AST_LOW_BYTE_ZERO: assert property (
        reg_rd_i && reg_addr_i inside {6'h21, 6'h24} |=> reg_rdata_o[7:0] == 8'h00)
        else $error("trim low byte not read as zero");
endmodule : ccr_properties
bind ccr_channel_calibration_config_regs ccr_properties u_props (.clk_i(clk_i), .rst_i(rst_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o), .global_highpass_setting_i(global_highpass_setting_i),
    .ch5_sample_delay_o(ch5_sample_delay_o), .ch5_highpass_en_o(ch5_highpass_en_o),
    .ch5_input_select_o(ch5_input_select_o), .ch4_gain_o(ch4_gain_o), .ch5_offset_o(ch5_offset_o));

// ===== bench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import ccr_pkg::*;
    logic clk_i = 0, rst_i = 1, wr = 0, rd = 0, ghp = 0, v4i = 0, v5i = 0, hit, hp, v4o, v5o;
    logic [5:0] addr = 0;
    logic [15:0] wd = 0, rdata;
    logic [15:0] sh [5] = '{16'h8000, 16'h0, 16'h0, 16'h0, 16'h0};
    logic signed [23:0] s4 = 0, p5 = 0, t5 = 0, o4, o5, off;
    logic signed [9:0] dly;
    logic [23:0] gain;
    ccr_src_t sel;
    int fails = 0, checks_done = 0;
    int unsigned st = 87928;
    always #2.5 clk_i = ~clk_i;
    ccr_channel_calibration_config_regs DUT (.clk_i(clk_i), .rst_i(rst_i), .reg_wr_i(wr),
        .reg_rd_i(rd), .reg_addr_i(addr), .reg_wdata_i(wd), .reg_rdata_o(rdata), .reg_hit_o(hit),
        .global_highpass_setting_i(ghp), .ch5_sample_delay_o(dly), .ch5_highpass_en_o(hp),
        .ch5_input_select_o(sel), .ch4_gain_o(gain), .ch5_offset_o(off), .ch4_valid_i(v4i),
        .ch4_sample_i(s4), .ch4_valid_o(v4o), .ch4_sample_o(o4), .ch5_valid_i(v5i),
        .ch5_pin_sample_i(p5), .ch5_test_level_i(t5), .ch5_valid_o(v5o), .ch5_sample_o(o5));
    function automatic int unsigned rnd();
        st ^= st << 13;
        st ^= st >> 17;
        st ^= st << 5;
        return st;
    endfunction : rnd
    function automatic logic [15:0] wmask(logic [5:0] a);
        // Low bytes of trim low words and setup bits 5:3 are not storable
        return a == 6'h21 || a == 6'h24 ? 16'hFF00 : a == 6'h22 ? 16'hFFC7 : 16'hFFFF;
    endfunction : wmask
    function automatic logic [23:0] sat(longint v);
        return v > 8388607 ? 24'h7FFFFF : v < -8388608 ? 24'h800000 : v[23:0];
    endfunction : sat
    task automatic chk(string n, logic [23:0] e, logic [23:0] g);
        checks_done++;
        if (g !== e) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic wreg(logic [5:0] a, logic [15:0] d);
        @(posedge clk_i);
        wr <= 1;
        addr <= a;
        wd <= d;
        @(posedge clk_i);
        wr <= 0;
        if (a >= 6'h20 && a <= 6'h24)
            sh[a-6'h20] = d & wmask(a);
    endtask : wreg
    task automatic rreg(logic [5:0] a);
        logic m;
        m = a >= 6'h20 && a <= 6'h24;
        @(posedge clk_i);
        rd <= 1;
        addr <= a;
        @(posedge clk_i);
        rd <= 0;
        @(posedge clk_i);
        #1;
        chk("rdata", m ? sh[a-6'h20] : 16'h0, rdata);
        chk("hit", m, hit);
    endtask : rreg
    task automatic outs();
        repeat (2) @(posedge clk_i);
        #1;
        chk("gain", {sh[0], sh[1][15:8]}, gain);
        chk("offset", {sh[3], sh[4][15:8]}, off);
        chk("delay", sh[2][15:6], {dly});
        chk("highpass", ghp & ~sh[2][2], hp);
        chk("select", sh[2][1:0], sel);
    endtask : outs
    task automatic stream();
        logic signed [23:0] a, b, c, o5t;
        logic [23:0] g4;
        longint src;
        // Full signed range so both saturation limits of channel 4 get hit
        a = 24'($signed(rnd()) >>> 8);
        b = $signed(rnd()) >>> 9;
        c = $signed(rnd()) >>> 9;
        g4 = {sh[0], sh[1][15:8]};
        o5t = {sh[3], sh[4][15:8]};
        src = sh[2][1:0] == 2'h0 ? b : sh[2][1:0] == 2'h1 ? 0 : sh[2][1:0] == 2'h2 ? c : -c;
        @(posedge clk_i);
        {v4i, v5i, s4, p5, t5} <= {2'b11, a, b, c};
        @(posedge clk_i);
        {v4i, v5i} <= 2'b00;
        #1;
        chk("ch4 valid", 1, v4o);
        chk("ch5 valid early", 0, v5o);
        chk("ch4 sample", sat((longint'(a) * longint'(g4)) >>> 23), o4);
        @(posedge clk_i);
        #1;
        chk("ch4 valid drop", 0, v4o);
        chk("ch5 valid", 1, v5o);
        chk("ch5 sample", sat(src + longint'(o5t)), o5);
    endtask : stream
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : final_report
    initial begin
        #100000;
        fails++;
        final_report();
    end
    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 0;
        @(posedge clk_i);
        #1;
        chk("gain after reset", 24'h800000, gain);
        for (int a = 6'h1E; a < 6'h28; a++) rreg(a);
        $display("reset values test done");
        foreach (sh[i]) wreg(6'h20 + i, 16'hFFFF);
        for (int a = 6'h1F; a < 6'h26; a++) rreg(a);
        outs();
        $display("all-ones test done");
        repeat (40) begin
            logic [5:0] a;
            a = 6'h1F + rnd() % 7;
            @(posedge clk_i);
            ghp <= 1'(rnd() & 1);
            wreg(a, rnd());
            rreg(a);
            outs();
        end
        $display("random access test done");
        // Reset again after writes: every word must fall back to its reset value
        @(posedge clk_i);
        rst_i <= 1;
        repeat (2) @(posedge clk_i);
        rst_i <= 0;
        sh = '{16'h8000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
        for (int a = 6'h20; a < 6'h25; a++) rreg(a);
        outs();
        $display("mid-run reset test done");
        for (int s = 0; s < 4; s++) begin
            wreg(6'h22, (rnd() & 16'hFFC4) | s);
            for (int a = 6'h20; a < 6'h25; a++) if (a != 6'h22) wreg(a, rnd());
            outs();
            repeat (3) stream();
        end
        $display("stream test done");
        final_report();
    end
endmodule : tb_top
